// [inc/dsw_pkg.sv]
// Package for the serial write frame receiver of a 16-bit converter.
// Assumes a single system clock; the serial pins are asynchronous to it.
package dsw_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int unsigned FRAME_BITS = 24;
    localparam int unsigned CODE_BITS = 16;
    localparam int unsigned CODE_LSB = 0;
    localparam int unsigned CTRL_LSB = 16;
    localparam int unsigned CTRL_BITS = 8;
    localparam int unsigned COUNT_BITS = 5;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [23:0] SHIFT_RESET = 24'h000000;

    // ------------------------------------------------------------
    // Synchroniser depth
    // ------------------------------------------------------------
    localparam int unsigned SYNC_STAGES = 2;

    // Committed word as seen by the converter core.
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] code;
    } dsw_word_type;

    // Synchronised serial pins.
    typedef struct packed {
        logic frame_n;
        logic sclk;
        logic sdata;
    } dsw_pins_type;

    typedef enum logic [1:0] {
        DSW_IDLE,
        DSW_SHIFT,
        DSW_DONE
    } dsw_state_type;

endpackage

// [src/dsw_sync.sv]
// Two-stage synchroniser for one asynchronous level input.
// Assumes the input is a pin unrelated to clk.
`timescale 1ns/1ps
module dsw_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;

    // The first stage feeds only the second stage, never other logic.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RESET_LEVEL;
            sync_out <= RESET_LEVEL;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// [src/dsw_receiver.sv]
// Serial write frame receiver: 24-bit frames, commit on the 24th bit.
// Assumes the serial clock is well below clk/4 so every edge is seen.
`timescale 1ns/1ps

// What this block does
// R1: Frame select is active low; bits accepted only while it is low.
// R2: Data sampled into a 24-bit shift register on serial clock falls.
// R3: After the 24th falling edge the word loads the conversion register.
// R4: Frame select rising before the 24th edge discards the partial frame.
// R5: Conversion code is unsigned straight binary, 0 to 65535.
// R6: Host sends MSB first and raises frame select between frames.
module dsw_receiver (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic sdata,
    output logic [15:0] analog_output,
    output logic [7:0] ctrl_word,
    output logic update_pulse,
    output logic abort_pulse,
    output logic busy
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Every pin passes two flip-flops before use. A serial clock phase
    // shorter than one cycle of clk can slip between samples, so the
    // host must keep each high and low phase at least that long.
    dsw_pkg::dsw_pins_type pins;
    logic frame_sync;
    logic sclk_sync;
    logic data_sync;

    // Select resets to its idle high level so no false fall follows reset.
    dsw_sync #(.RESET_LEVEL(1'b1)) u_sync_frame (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(frame_sel_n),
        .sync_out(frame_sync)
    );

    // Clock and data pass the same depth, so their skew is unchanged.
    dsw_sync #(.RESET_LEVEL(1'b0)) u_sync_sclk (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(sclk),
        .sync_out(sclk_sync)
    );

    dsw_sync #(.RESET_LEVEL(1'b0)) u_sync_data (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(sdata),
        .sync_out(data_sync)
    );

    // A single driver for the whole carrier keeps every bit one-sourced.
    assign pins = '{
        frame_n: frame_sync,
        sclk: sclk_sync,
        sdata: data_sync
    };

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    logic sclk_prev_q;
    logic frame_prev_q;
    logic sclk_fall;
    logic frame_fall;
    logic frame_rise;

    // Edges come from synchronised copies only, never the raw pins.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= pins.sclk;
        end
    end

    // The select history resets high, matching the idle level of its pin.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_prev_q <= 1'b1;
        end else begin
            frame_prev_q <= pins.frame_n;
        end
    end

    // Data and clock share synchroniser depth, so data still holds here.
    assign sclk_fall = sclk_prev_q && !pins.sclk;
    assign frame_fall = frame_prev_q && !pins.frame_n;
    assign frame_rise = !frame_prev_q && pins.frame_n;

    // ------------------------------------------------------------
    // Frame state machine
    // ------------------------------------------------------------
    dsw_pkg::dsw_state_type state_q;
    logic [dsw_pkg::COUNT_BITS-1:0] count_q;
    logic [dsw_pkg::FRAME_BITS-1:0] shift_q;
    logic last_bit;
    logic frame_open;
    logic [dsw_pkg::FRAME_BITS-1:0] frame_word;

    // The 24th fall is the one seen while the count stands at 23.
    assign last_bit = sclk_fall &&
        (count_q == 5'(dsw_pkg::FRAME_BITS - 1));

    // Bits are taken only in SHIFT and only while select is still low.
    assign frame_open = state_q == dsw_pkg::DSW_SHIFT && !pins.frame_n;

    // The full word is the bits already held plus the bit on the line.
    assign frame_word = {shift_q[dsw_pkg::FRAME_BITS-2:0], pins.sdata};

    // A frame opens on the falling select; edges before it are ignored.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= dsw_pkg::DSW_IDLE;
        end else begin
            case (state_q)
                dsw_pkg::DSW_IDLE: begin
                    // Clock falls seen before the frame opens are dropped.
                    if (frame_fall) begin
                        state_q <= dsw_pkg::DSW_SHIFT; // [R1]
                    end
                end
                dsw_pkg::DSW_SHIFT: begin
                    if (pins.frame_n) begin
                        state_q <= dsw_pkg::DSW_IDLE; // [R4]
                    end else if (last_bit) begin
                        state_q <= dsw_pkg::DSW_DONE; // [R3]
                    end
                end
                dsw_pkg::DSW_DONE: begin
                    // Extra clocks are ignored until select rises.
                    if (pins.frame_n) begin
                        state_q <= dsw_pkg::DSW_IDLE; // [R6]
                    end
                end
                default: begin
                    state_q <= dsw_pkg::DSW_IDLE;
                end
            endcase
        end
    end

    // Bit counter restarts at every frame so each frame starts empty.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (state_q != dsw_pkg::DSW_SHIFT) begin
            count_q <= '0;
        end else if (frame_open && sclk_fall) begin
            count_q <= count_q + 5'h1; // [R2]
        end
    end

    // Shift register, MSB first, sampled only inside an open frame.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_q <= dsw_pkg::SHIFT_RESET;
        end else if (frame_open && sclk_fall) begin
            shift_q <= frame_word; // [R2] [R6]
        end
    end

    // ------------------------------------------------------------
    // Conversion register
    // ------------------------------------------------------------
    dsw_pkg::dsw_word_type word_q;
    logic commit;

    // Abort has priority: select high in the same cycle blocks the load.
    assign commit = frame_open && last_bit;

    // Low 16 bits are the straight binary code, zero after reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            word_q.code <= dsw_pkg::CODE_RESET;
            word_q.ctrl <= dsw_pkg::CTRL_RESET;
        end else if (commit) begin
            word_q.code <= frame_word[dsw_pkg::CODE_LSB +:
                                      dsw_pkg::CODE_BITS]; // [R3] [R5]
            word_q.ctrl <= frame_word[dsw_pkg::CTRL_LSB +:
                                      dsw_pkg::CTRL_BITS]; // [R3]
        end
    end

    // The update pulse is registered, so it lines up with the new word.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            update_pulse <= 1'b0;
        end else begin
            update_pulse <= commit; // [R3]
        end
    end

    // The abort pulse marks a frame cut short; only busy falls with it.
    // A rise in DONE is the normal close of a frame and raises no abort.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            abort_pulse <= 1'b0;
        end else begin
            abort_pulse <= state_q == dsw_pkg::DSW_SHIFT &&
                frame_rise; // [R4]
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Both words come straight from flip-flops and move only in the
    // cycle of update_pulse, so the core may sample them at any time.
    assign analog_output = word_q.code; // [R5]
    assign ctrl_word = word_q.ctrl;

    // Busy spans the open frame only; it drops on the 24th bit or abort.
    assign busy = state_q == dsw_pkg::DSW_SHIFT;

endmodule

// [test/dsw_receiver_props.sv]
// Checker for the serial write frame receiver output timing.
// Assumes it is bound to dsw_receiver and sees only its ports.
`timescale 1ns/1ps
module dsw_receiver_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_sel_n,
    input wire logic sclk,
    input wire logic sdata,
    input wire logic [15:0] analog_output,
    input wire logic [7:0] ctrl_word,
    input wire logic update_pulse,
    input wire logic abort_pulse,
    input wire logic busy
);
    // All checks share the system clock and its synchronous reset.
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_update_single: assert property
        (update_pulse |=> !update_pulse)
        else $error("update pulse lasted more than one cycle");
    chk_code_moves: assert property
        ($changed(analog_output) |-> update_pulse)
        else $error("code changed without an update");
    chk_ctrl_moves: assert property
        ($changed(ctrl_word) |-> update_pulse)
        else $error("control byte changed without an update");
    chk_idle_quiet: assert property
        (frame_sel_n [*6] |-> !busy)
        else $error("busy while select has been high");
    chk_abort_cause: assert property
        (abort_pulse |-> $past(frame_sel_n, 2))
        else $error("abort without a select rise");
    chk_abort_alone: assert property
        (abort_pulse |-> !update_pulse ##1 !busy)
        else $error("abort together with update or busy");
    chk_update_framed: assert property
        (update_pulse |-> !$past(frame_sel_n, 3))
        else $error("update without select low");
    chk_done_closes: assert property
        (update_pulse |-> !busy)
        else $error("frame still open after the word was loaded");
endmodule
bind dsw_receiver dsw_receiver_props dsw_receiver_props_i (.clk(clk),
    .rst_n(rst_n), .frame_sel_n(frame_sel_n), .sclk(sclk), .sdata(sdata),
    .analog_output(analog_output), .ctrl_word(ctrl_word),
    .update_pulse(update_pulse), .abort_pulse(abort_pulse), .busy(busy));

// [test/dsw_host_model.sv]
// Host side of the three-wire write port with a 64 ns serial clock.
// Assumes the bench calls send; the serial clock is still between frames.
`timescale 1ns/1ps
module dsw_host_model (
    output logic frame_sel_n,
    output logic sclk,
    output logic sdata
);
    initial begin
        frame_sel_n = 1'b1;
        sclk = 1'b1;
        sdata = 1'b0;
    end
    // Shifts n bits, MSB first; bits past the 24th repeat the inverse LSB.
    task automatic send(input logic [23:0] w, input int n);
        frame_sel_n = 1'b0;
        #32;
        for (int i = 0; i < n; i++) begin
            sdata = (i < 24) ? w[23 - i] : ~w[0];
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
            #32;
        end
        sclk = 1'b1;
        sdata = ~sdata; // Released line shows no stale bit.
        #32;
        frame_sel_n = 1'b1;
        #100;
    endtask
endmodule

// [test/testbench.sv]
// Self-checking bench for the serial write frame receiver.
// Assumes dsw_host_model drives the pins and the checker is bound.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic frame_sel_n, sclk, sdata, update_pulse, abort_pulse, busy;
    logic [15:0] analog_output;
    logic [7:0] ctrl_word;
    int n_fail = 0;
    int checks = 0;
    int n_upd = 0;
    int n_abt = 0;
    int n_busy = 0;
    always #2.5 clk = ~clk;
    dsw_host_model dsw_host_model_i (.frame_sel_n(frame_sel_n),
        .sclk(sclk), .sdata(sdata));
    dsw_receiver dsw_receiver_i (.clk(clk), .rst_n(rst_n),
        .frame_sel_n(frame_sel_n), .sclk(sclk), .sdata(sdata),
        .analog_output(analog_output), .ctrl_word(ctrl_word),
        .update_pulse(update_pulse), .abort_pulse(abort_pulse), .busy(busy));
    // Pulses last one cycle, so they are counted on every edge; busy too.
    always @(posedge clk) begin
        if (update_pulse === 1'b1) n_upd++;
        if (abort_pulse === 1'b1) n_abt++;
        if (busy === 1'b1) n_busy++;
    end
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // One frame of n clocks, then pulse counts and the committed word.
    task automatic frame(input logic [23:0] w, input int n, input int upd,
        input int abt, input logic [23:0] exp);
        int u;
        int a;
        int b;
        u = n_upd;
        a = n_abt;
        b = n_busy;
        dsw_host_model_i.send(w, n);
        check("updates", n_upd - u, upd);
        check("busy seen", n_busy != b, 1);
        check("busy after", busy, 0);
        check("aborts", n_abt - a, abt);
        check("word", {ctrl_word, analog_output}, exp);
    endtask
    task automatic t_reset;
        check("reset word", {busy, ctrl_word, analog_output}, 0);
    endtask
    task automatic t_full;
        frame(24'h3cffff, 24, 1, 0, 24'h3cffff);
        frame(24'hc30000, 24, 1, 0, 24'hc30000);
        frame(24'h5a8001, 24, 1, 0, 24'h5a8001);
    endtask
    task automatic t_abort;
        frame(24'h001234, 23, 0, 1, 24'h5a8001);
    endtask
    task automatic t_extra;
        frame(24'h7e4321, 26, 1, 0, 24'h7e4321);
    endtask
    // Reset is driven off the sampling edge, then the scenarios run.
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        t_reset();
        t_full();
        t_abort();
        t_extra();
        stop_test();
    end
    // The five frames need under 10 us; a hang is cut off well beyond it.
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule
